// >>> src/vic_pkg.sv
package vic_pkg;
	// Source counts and index widths
	localparam int TRAP_NUM = 6;
	localparam int SRC_NUM = 246;
	localparam int EN_BITS = 256;
	localparam int PRIO_SLOTS = 248;
	localparam int VEC_W = 8;
	localparam int LVL_W = 3;
	localparam int PC_W = 24;
	localparam int BOOT_LIM_W = 13;
	localparam int ADR_W = 12;
	// Vector tables
	localparam logic [23:0] PRIMARY_BASE = 24'h00_0004;
	localparam logic [10:0] PAGE_ZERO_LSBS = 11'h000;
	localparam logic [12:0] MIN_BOOT_PAGES = 13'h0002;
	localparam logic [12:0] ONE_PAGE = 13'h0001;
	localparam logic [23:0] RESET_VECTOR = 24'h00_0000;
	// Register offsets
	localparam logic [11:0] OFS_CTRL2 = 12'h000;
	localparam logic [11:0] OFS_STATE = 12'h004;
	localparam logic [11:0] OFS_EVT = 12'h008;
	localparam logic [11:0] OFS_MASK = 12'h00C;
	localparam logic [11:0] OFS_EN = 12'h040;
	localparam logic [11:0] OFS_EN_END = 12'h060;
	localparam logic [11:0] OFS_PRIO = 12'h080;
	localparam logic [11:0] OFS_PRIO_END = 12'h0FC;
	// Field positions
	localparam int CTRL2_ALT_EN_BIT = 8;
	localparam int ST_ALT_ACTIVE_BIT = 0;
	localparam int ST_ALT_AVAIL_BIT = 1;
	localparam int ST_VEC_LSB = 8;
	localparam int PRIO_FIELD_STRIDE = 4;
	localparam int PRIO_PER_WORD = 8;
	localparam int EVT_W = 3;
	localparam int EVT_DISPATCH = 0;
	localparam int EVT_TRAP = 1;
	localparam int EVT_ALT_REFUSED = 2;
	// Reset values
	localparam logic [2:0] EVT_RESET = 3'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [7:0] VEC_RESET = 8'h00;
	localparam logic [7:0] TRAP_COUNT = 8'h06;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_FETCH = 5'h02,
		ST_WAIT = 5'h04,
		ST_SERVE = 5'h08,
		ST_RETURN = 5'h10
	} fsm_type;
endpackage

// >>> src/cfg_sync.sv
`timescale 1ns/100ps
module cfg_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] stage_ff;

	// Two flops; first stage feeds only the second
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			stage_ff <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage_ff <= async_in;
			sync_out <= stage_ff;
		end
	end
endmodule // cfg_sync

// >>> src/prio_select.sv
`timescale 1ns/100ps
module prio_select (
	// Sources
	input wire logic [vic_pkg::SRC_NUM-1:0] req,
	input wire logic [vic_pkg::EN_BITS-1:0] en,
	input wire logic [vic_pkg::PRIO_SLOTS-1:0][vic_pkg::LVL_W-1:0] prio,
	// Winner
	output logic win_valid,
	output logic [vic_pkg::VEC_W-1:0] win_idx,
	output logic [vic_pkg::LVL_W-1:0] win_lvl
);
	// highest level wins
	// Scan from the top down so that on equal level the lowest index wins
	always_comb
	begin
		win_valid = 1'b0;
		win_idx = '0;
		win_lvl = '0;
		for (int i = vic_pkg::SRC_NUM - 1; i >= 0; i--)
		begin
			if (req[i] && en[i] && prio[i] != '0 && prio[i] >= win_lvl)
			begin
				win_valid = 1'b1;
				win_idx = i[vic_pkg::VEC_W-1:0];
				win_lvl = prio[i];
			end
		end
	end
endmodule // prio_select

// >>> src/vector_irq_ctrl.sv
// What this block does
// - Merge all peripheral requests into one core request
// - Six traps, never masked by enables or levels
// - Seven software priority levels per source
// - Equal level: lowest vector index wins
// - Primary table at 000004h, traps then 246 sources
// - Every source has its own vector slot
// - Hand core the 24-bit handler address fetched
// - Fixed entry and return latency for all sources
// - Alternate table needs config and enable bit 8
// - Alternate table active: all vectors fetched there
// - Alternate base is last boot segment page start
// - Alternate table needs boot segment of two pages
// - Vector fetches carry boot segment code protection
// - Reset bypasses controller, clears state, vector zero
`timescale 1ns/100ps
module vector_irq_ctrl (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [vic_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Request sources
	input wire logic [vic_pkg::SRC_NUM-1:0] irq_req,
	input wire logic [vic_pkg::TRAP_NUM-1:0] trap_req,
	// Configuration pins
	input wire logic alt_table_config_disable,
	input wire logic [vic_pkg::BOOT_LIM_W-1:0] boot_segment_limit,
	input wire logic boot_segment_protect,
	// Core side
	input wire logic [vic_pkg::LVL_W-1:0] core_ipl,
	input wire logic core_ack,
	input wire logic core_ret,
	output logic core_irq,
	output logic [vic_pkg::VEC_W-1:0] core_vec_num,
	output logic [vic_pkg::PC_W-1:0] handler_addr,
	output logic handler_valid,
	output logic ret_done,
	// Program memory vector fetch
	output logic pm_rd,
	output logic [vic_pkg::PC_W-1:0] pm_addr,
	output logic pm_secure,
	input wire logic [vic_pkg::PC_W-1:0] pm_rdata,
	// System interrupt
	output logic sys_irq
);
	typedef struct packed {
		vic_pkg::fsm_type fsm;
		logic alt_en;
		logic [vic_pkg::EVT_W-1:0] evt;
		logic [vic_pkg::EVT_W-1:0] mask;
		logic [vic_pkg::EN_BITS-1:0] en;
		logic [vic_pkg::PRIO_SLOTS-1:0][vic_pkg::LVL_W-1:0] prio;
		logic ack;
		logic [31:0] rdata;
		logic irq;
		logic [vic_pkg::VEC_W-1:0] pend_vec;
		logic [vic_pkg::VEC_W-1:0] cur_vec;
		logic pm_rd;
		logic [vic_pkg::PC_W-1:0] pm_addr;
		logic secure;
		logic [vic_pkg::PC_W-1:0] handler;
		logic hvalid;
		logic ret_done;
		logic sys_irq;
	} state_type;

	state_type s;
	state_type n;
	logic cfg_dis_s;
	logic prot_s;
	logic [vic_pkg::BOOT_LIM_W-1:0] boot_lim_s;
	logic win_valid;
	logic [vic_pkg::VEC_W-1:0] win_idx;
	logic [vic_pkg::LVL_W-1:0] win_lvl;
	logic alt_avail;
	logic alt_active;
	logic [vic_pkg::PC_W-1:0] fetch_base;
	logic [vic_pkg::VEC_W-1:0] trap_vec;
	logic trap_any;

	////////////////////////////////////////////////////////////////////////////////
	cfg_sync #(.W(vic_pkg::BOOT_LIM_W + 2)) u_cfg_sync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.async_in({alt_table_config_disable, boot_segment_protect, boot_segment_limit}),
		.sync_out({cfg_dis_s, prot_s, boot_lim_s})
	);

	prio_select u_prio_select (
		.req(irq_req),
		.en(s.en),
		.prio(s.prio),
		.win_valid(win_valid),
		.win_idx(win_idx),
		.win_lvl(win_lvl)
	);

	////////////////////////////////////////////////////////////////////////////////
	// alternate table gating
	assign alt_avail = cfg_dis_s && (boot_lim_s >= vic_pkg::MIN_BOOT_PAGES);
	assign alt_active = alt_avail && s.alt_en;
	assign fetch_base = alt_active ? {boot_lim_s - vic_pkg::ONE_PAGE, vic_pkg::PAGE_ZERO_LSBS} : vic_pkg::PRIMARY_BASE;

	always_comb
	begin
		trap_vec = '0;
		trap_any = 1'b0;
		for (int t = vic_pkg::TRAP_NUM - 1; t >= 0; t--)
		begin
			if (trap_req[t])
			begin
				trap_any = 1'b1;
				trap_vec = t[vic_pkg::VEC_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		logic [31:0] wmask;
		logic [31:0] merged;
		logic [vic_pkg::EVT_W-1:0] evt_set;
		logic [vic_pkg::EVT_W-1:0] evt_clr;
		logic [vic_pkg::ADR_W-1:0] rel;
		int k;
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		merged = '0;
		evt_set = '0;
		evt_clr = '0;
		rel = '0;
		k = 0;
		n = s;
		n.ack = 1'b0;
		n.rdata = '0;
		n.pm_rd = 1'b0;
		n.hvalid = 1'b0;
		n.ret_done = 1'b0;

		// Bus: answer one cycle after the strobe, unmapped reads give zero
		if (wb_cyc_i && wb_stb_i && !s.ack)
		begin
			n.ack = 1'b1;
			if (wb_adr_i == vic_pkg::OFS_CTRL2)
			begin
				n.rdata[vic_pkg::CTRL2_ALT_EN_BIT] = s.alt_en;
				if (wb_we_i && wb_sel_i[1])
					n.alt_en = wb_dat_i[vic_pkg::CTRL2_ALT_EN_BIT];
			end
			else if (wb_adr_i == vic_pkg::OFS_STATE)
			begin
				n.rdata[vic_pkg::ST_ALT_ACTIVE_BIT] = alt_active;
				n.rdata[vic_pkg::ST_ALT_AVAIL_BIT] = alt_avail;
				n.rdata[vic_pkg::ST_VEC_LSB +: vic_pkg::VEC_W] = s.cur_vec;
			end
			else if (wb_adr_i == vic_pkg::OFS_EVT)
			begin
				n.rdata[vic_pkg::EVT_W-1:0] = s.evt;
				if (wb_we_i && wb_sel_i[0])
					evt_clr = wb_dat_i[vic_pkg::EVT_W-1:0];
			end
			else if (wb_adr_i == vic_pkg::OFS_MASK)
			begin
				n.rdata[vic_pkg::EVT_W-1:0] = s.mask;
				if (wb_we_i && wb_sel_i[0])
					n.mask = wb_dat_i[vic_pkg::EVT_W-1:0];
			end
			else if (wb_adr_i >= vic_pkg::OFS_EN && wb_adr_i < vic_pkg::OFS_EN_END)
			begin
				rel = wb_adr_i - vic_pkg::OFS_EN;
				k = int'(rel[vic_pkg::ADR_W-1:2]);
				n.rdata = s.en[k*32 +: 32];
				if (wb_we_i)
					n.en[k*32 +: 32] = (s.en[k*32 +: 32] & ~wmask) | (wb_dat_i & wmask);
				n.en[vic_pkg::EN_BITS-1:vic_pkg::SRC_NUM] = '0;
			end
			else if (wb_adr_i >= vic_pkg::OFS_PRIO && wb_adr_i < vic_pkg::OFS_PRIO_END)
			begin
				rel = wb_adr_i - vic_pkg::OFS_PRIO;
				k = int'(rel[vic_pkg::ADR_W-1:2]);
				for (int j = 0; j < vic_pkg::PRIO_PER_WORD; j++)
				begin
					merged[j*vic_pkg::PRIO_FIELD_STRIDE +: vic_pkg::LVL_W] = s.prio[k*vic_pkg::PRIO_PER_WORD + j];
				end
				n.rdata = merged;
				merged = (merged & ~wmask) | (wb_dat_i & wmask);
				for (int j = 0; j < vic_pkg::PRIO_PER_WORD; j++)
				begin
					if (wb_we_i && (k*vic_pkg::PRIO_PER_WORD + j) < vic_pkg::SRC_NUM)
						n.prio[k*vic_pkg::PRIO_PER_WORD + j] = merged[j*vic_pkg::PRIO_FIELD_STRIDE +: vic_pkg::LVL_W];
				end
			end
		end

		// Request to the core, recomputed each idle cycle
		unique case (s.fsm)
			vic_pkg::ST_IDLE:
			begin
				if (s.irq && core_ack)
				begin
					n.irq = 1'b0;
					n.cur_vec = s.pend_vec;
					n.pm_rd = 1'b1;
					n.pm_addr = fetch_base + {{(vic_pkg::PC_W-vic_pkg::VEC_W-1){1'b0}}, s.pend_vec, 1'b0};
					n.secure = prot_s;
					n.fsm = vic_pkg::ST_FETCH;
				end
				else if (trap_any)
				begin
					n.irq = 1'b1;
					n.pend_vec = trap_vec;
					evt_set[vic_pkg::EVT_TRAP] = 1'b1;
				end
				else if (win_valid && win_lvl > core_ipl)
				begin
					n.irq = 1'b1;
					n.pend_vec = win_idx + vic_pkg::TRAP_COUNT;
				end
				else
					n.irq = 1'b0;
			end
			vic_pkg::ST_FETCH:
				n.fsm = vic_pkg::ST_WAIT;
			vic_pkg::ST_WAIT:
			begin
				n.handler = pm_rdata;
				n.hvalid = 1'b1;
				evt_set[vic_pkg::EVT_DISPATCH] = 1'b1;
				n.fsm = vic_pkg::ST_SERVE;
			end
			vic_pkg::ST_SERVE:
			begin
				if (core_ret)
					n.fsm = vic_pkg::ST_RETURN;
			end
			vic_pkg::ST_RETURN:
			begin
				n.ret_done = 1'b1;
				n.fsm = vic_pkg::ST_IDLE;
			end
			default:
				n.fsm = vic_pkg::ST_IDLE;
		endcase

		evt_set[vic_pkg::EVT_ALT_REFUSED] = s.alt_en && !alt_avail;
		// Set wins over a same-cycle write-one clear
		n.evt = (s.evt & ~evt_clr) | evt_set;
		n.sys_irq = |(n.evt & n.mask);
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.fsm <= vic_pkg::ST_IDLE;
			s.evt <= vic_pkg::EVT_RESET;
			s.mask <= vic_pkg::MASK_RESET;
			s.pend_vec <= vic_pkg::VEC_RESET;
			s.cur_vec <= vic_pkg::VEC_RESET;
			s.handler <= vic_pkg::RESET_VECTOR;
		end
		else
			s <= n;
	end

	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.rdata;
	assign core_irq = s.irq;
	assign core_vec_num = s.cur_vec;
	assign handler_addr = s.handler;
	assign handler_valid = s.hvalid;
	assign ret_done = s.ret_done;
	assign pm_rd = s.pm_rd;
	assign pm_addr = s.pm_addr;
	assign pm_secure = s.secure;
	assign sys_irq = s.sys_irq;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	sequence seq_take;
		s.fsm == vic_pkg::ST_IDLE && s.irq && core_ack;
	endsequence
	sequence seq_fetch;
		pm_rd && s.fsm == vic_pkg::ST_FETCH ##1 s.fsm == vic_pkg::ST_WAIT;
	endsequence

	AST_REQ_HAS_SOURCE: assert property ($rose(core_irq) |-> $past(trap_any || win_valid)) else $error("core request without source");
	AST_TRAP_UNMASKED: assert property (s.fsm == vic_pkg::ST_IDLE && trap_any && !(s.irq && core_ack) |=> core_irq && s.pend_vec < vic_pkg::TRAP_COUNT) else $error("trap not raised");
	AST_LEVEL_ABOVE_IPL: assert property ($rose(core_irq) && s.pend_vec >= vic_pkg::TRAP_COUNT |-> $past(win_lvl) > $past(core_ipl) && !$past(trap_any)) else $error("request at or below core level");
	AST_TIE_LOWEST: assert property (win_valid && irq_req[0] && s.en[0] && s.prio[0] == win_lvl |-> win_idx == '0) else $error("tie not won by vector zero");
	AST_PRIMARY_ADDR: assert property (seq_take ##0 !alt_active |=> pm_addr == vic_pkg::PRIMARY_BASE + {15'h0000, s.cur_vec, 1'b0}) else $error("primary fetch address wrong");
	AST_ALT_ADDR: assert property (seq_take ##0 alt_active |=> pm_addr == {$past(boot_lim_s) - vic_pkg::ONE_PAGE, vic_pkg::PAGE_ZERO_LSBS} + {15'h0000, s.cur_vec, 1'b0}) else $error("alternate fetch address wrong");
	AST_ALT_NEEDS_PAGES: assert property (boot_lim_s < vic_pkg::MIN_BOOT_PAGES || !cfg_dis_s |-> !alt_active) else $error("alternate table active when unavailable");
	AST_ENTRY_LATENCY: assert property (seq_take |=> seq_fetch ##1 handler_valid) else $error("entry latency not fixed");
	AST_HANDLER_DATA: assert property (handler_valid |-> handler_addr == $past(pm_rdata) && $past(s.fsm) == vic_pkg::ST_WAIT) else $error("handler address not from fetch");
	AST_RETURN_LATENCY: assert property (s.fsm == vic_pkg::ST_SERVE && core_ret |=> ##1 ret_done ##1 !ret_done) else $error("return latency not fixed");
	AST_SECURE_FETCH: assert property (seq_take |=> pm_secure == $past(prot_s)) else $error("fetch protection wrong");
endmodule // vector_irq_ctrl

// >>> test/core_model.sv
`timescale 1ns/100ps
module core_model #(
	parameter logic [23:0] KEY = 24'h5A_A5C3
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// Controller side
	input wire logic core_irq,
	input wire logic handler_valid,
	input wire logic ret_done,
	input wire logic pm_rd,
	input wire logic [23:0] pm_addr,
	output logic core_ack,
	output logic core_ret,
	output logic [23:0] pm_rdata,
	// Answer delay in cycles
	input wire logic [3:0] delay
);
	logic busy;
	logic serve;
	logic [3:0] cnt;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{core_ack, core_ret, busy, serve, cnt} <= '0;
			pm_rdata <= 24'h00_0000;
		end
		else
		begin
			core_ack <= 1'b0;
			core_ret <= 1'b0;
			cnt <= 4'h0;
			// Word is valid only in the cycle after the read
			pm_rdata <= pm_rd ? (pm_addr ^ KEY) : ~pm_rdata;
			if (handler_valid)
				serve <= 1'b1;
			if (ret_done)
				busy <= 1'b0;
			if (!busy && core_irq && !core_ack)
			begin
				cnt <= cnt + 4'h1;
				core_ack <= (cnt == delay);
				busy <= (cnt == delay);
			end
			if (serve)
			begin
				cnt <= cnt + 4'h1;
				core_ret <= (cnt == delay);
				serve <= (cnt != delay);
			end
		end
	end
endmodule // core_model

// >>> test/tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top;
	localparam logic [23:0] KEY = 24'h5A_A5C3;
	typedef struct { logic [5:0] t; int a; int la; int b; int lb; logic [7:0] v; } row_type;
	row_type rows [7] = '{'{6'h20, -1, 0, -1, 0, 8'h05}, '{6'h24, -1, 0, -1, 0, 8'h02},
		'{6'h00, 0, 1, -1, 0, 8'h06}, '{6'h00, 245, 7, -1, 0, 8'hFB}, '{6'h00, 10, 3, 3, 3, 8'h09},
		'{6'h00, 3, 3, 100, 7, 8'h6A}, '{6'h01, 0, 7, -1, 0, 8'h00}};
	logic ref_clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
	logic [245:0] irq_req = '0;
	logic [5:0] trap_req = 6'h00;
	logic alt_table_config_disable = 1'b0, boot_segment_protect = 1'b0;
	logic [12:0] boot_segment_limit = 13'h0000;
	logic [2:0] core_ipl = 3'h0;
	logic [3:0] dly = 4'h0;
	logic wb_ack_o, core_ack, core_ret, core_irq, handler_valid, ret_done, pm_rd, pm_secure, sys_irq, fetch_sec;
	logic [7:0] core_vec_num;
	logic [23:0] handler_addr, pm_addr, pm_rdata, fetch_adr;
	int checks = 0, num_errors = 0, cyc = 0, t_ack = 0, t_ret = 0;
	always #2.5 ref_clk = ~ref_clk;
	vector_irq_ctrl vector_irq_ctrl_i (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_req(irq_req), .trap_req(trap_req),
		.alt_table_config_disable(alt_table_config_disable), .boot_segment_limit(boot_segment_limit),
		.boot_segment_protect(boot_segment_protect), .core_ipl(core_ipl), .core_ack(core_ack),
		.core_ret(core_ret), .core_irq(core_irq), .core_vec_num(core_vec_num), .handler_addr(handler_addr),
		.handler_valid(handler_valid), .ret_done(ret_done), .pm_rd(pm_rd), .pm_addr(pm_addr),
		.pm_secure(pm_secure), .pm_rdata(pm_rdata), .sys_irq(sys_irq));
	core_model #(.KEY(KEY)) core_model_i (.ref_clk(ref_clk), .resetn(resetn), .core_irq(core_irq),
		.handler_valid(handler_valid), .ret_done(ret_done), .pm_rd(pm_rd), .pm_addr(pm_addr),
		.core_ack(core_ack), .core_ret(core_ret), .pm_rdata(pm_rdata), .delay(dly));
	////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		if (pm_rd === 1'b1)
			{fetch_adr, fetch_sec} <= {pm_addr, pm_secure};
		if (core_ack === 1'b1)
			t_ack <= cyc;
		if (core_ret === 1'b1)
			t_ret <= cyc;
		if (cyc == 30000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic set_src(int i, int l);
		logic [31:0] q;
		if (i < 0)
			return;
		wb(1'b0, vic_pkg::OFS_EN + 12'(4 * (i / 32)), 32'h0000_0000, q);
		wb(1'b1, vic_pkg::OFS_EN + 12'(4 * (i / 32)), q | (32'h0000_0001 << (i % 32)), q);
		wb(1'b0, vic_pkg::OFS_PRIO + 12'(4 * (i / 8)), 32'h0000_0000, q);
		q[4 * (i % 8) +: 3] = 3'(l);
		wb(1'b1, vic_pkg::OFS_PRIO + 12'(4 * (i / 8)), q, q);
	endtask
	task automatic arm(int a, int la, int b, int lb);
		logic [31:0] q;
		for (int w = 0; w < 8; w++)
			wb(1'b1, vic_pkg::OFS_EN + 12'(4 * w), 32'h0000_0000, q);
		set_src(a, la);
		set_src(b, lb);
	endtask
	task automatic serve(logic [5:0] t, int a, int b, logic [7:0] v, logic [23:0] base);
		logic [245:0] r = '0;
		logic [23:0] ea = base + {15'h0000, v, 1'b0};
		int n = 0;
		if (a >= 0)
			r[a] = 1'b1;
		if (b >= 0)
			r[b] = 1'b1;
		@(posedge ref_clk);
		{irq_req, trap_req} <= {r, t};
		do @(posedge ref_clk); while (handler_valid !== 1'b1 && ++n < 80);
		`CHK("vector", v, core_vec_num)
		`CHK("handler", ea ^ KEY, handler_addr)
		`CHK("fetch", ea, fetch_adr)
		`CHK("secure", boot_segment_protect, fetch_sec)
		`CHK("entry", 3, cyc - t_ack)
		{irq_req, trap_req} <= '0;
		do @(posedge ref_clk); while (ret_done !== 1'b1 && ++n < 160);
		`CHK("return", 2, cyc - t_ret)
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] q;
		int hi = 0;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		foreach (rows[k])
		begin
			dly <= (k % 2) ? 4'h3 : 4'h0;
			arm(rows[k].a, rows[k].la, rows[k].b, rows[k].lb);
			serve(rows[k].t, rows[k].a, rows[k].b, rows[k].v, vic_pkg::PRIMARY_BASE);
		end
		arm(20, 4, -1, 0);
		core_ipl <= 3'h4;
		irq_req[20] <= 1'b1;
		repeat (12)
		begin
			@(posedge ref_clk);
			hi += (core_irq !== 1'b0);
		end
		`CHK("gated", 0, hi)
		core_ipl <= 3'h3;
		serve(6'h00, 20, -1, 8'h1A, vic_pkg::PRIMARY_BASE);
		core_ipl <= 3'h7;
		serve(6'h08, -1, -1, 8'h03, vic_pkg::PRIMARY_BASE);
		{boot_segment_limit, alt_table_config_disable, boot_segment_protect} <= {13'h0004, 2'b11};
		wb(1'b1, vic_pkg::OFS_CTRL2, 32'h0000_0100, q);
		wb(1'b0, vic_pkg::OFS_CTRL2, 32'h0000_0000, q);
		`CHK("ctrl", 32'h0000_0100, q)
		wb(1'b0, vic_pkg::OFS_STATE, 32'h0000_0000, q);
		`CHK("alt_on", 2'b11, q[1:0])
		serve(6'h02, -1, -1, 8'h01, 24'h00_1800);
		core_ipl <= 3'h0;
		serve(6'h00, 20, -1, 8'h1A, 24'h00_1800);
		boot_segment_limit <= 13'h0001;
		wb(1'b0, vic_pkg::OFS_STATE, 32'h0000_0000, q);
		wb(1'b0, vic_pkg::OFS_STATE, 32'h0000_0000, q);
		`CHK("small", 2'b00, q[1:0])
		serve(6'h02, -1, -1, 8'h01, vic_pkg::PRIMARY_BASE);
		{boot_segment_limit, alt_table_config_disable} <= {13'h0004, 1'b0};
		wb(1'b0, vic_pkg::OFS_STATE, 32'h0000_0000, q);
		wb(1'b0, vic_pkg::OFS_STATE, 32'h0000_0000, q);
		`CHK("no_cfg", 2'b00, q[1:0])
		wb(1'b1, vic_pkg::OFS_CTRL2, 32'h0000_0000, q);
		wb(1'b0, vic_pkg::OFS_EVT, 32'h0000_0000, q);
		`CHK("events", 3'h7, q[2:0])
		repeat (2) @(posedge ref_clk);
		`CHK("mask_off", 1'b0, sys_irq)
		wb(1'b1, vic_pkg::OFS_MASK, 32'h0000_0007, q);
		repeat (2) @(posedge ref_clk);
		`CHK("mask", 1'b1, sys_irq)
		wb(1'b1, vic_pkg::OFS_EVT, 32'h0000_0007, q);
		wb(1'b0, vic_pkg::OFS_EVT, 32'h0000_0000, q);
		`CHK("w1c", 32'h0000_0000, q)
		repeat (2) @(posedge ref_clk);
		`CHK("sys_irq", 1'b0, sys_irq)
		wb(1'b1, 12'h800, 32'hFFFF_FFFF, q);
		wb(1'b0, 12'h800, 32'h0000_0000, q);
		`CHK("unmapped", 32'h0000_0000, q)
		wb_sel_i <= 4'h1;
		wb(1'b1, vic_pkg::OFS_CTRL2, 32'h0000_0100, q);
		wb(1'b0, vic_pkg::OFS_CTRL2, 32'h0000_0000, q);
		`CHK("lane", 32'h0000_0000, q)
		wb_sel_i <= 4'hF;
		wb(1'b1, vic_pkg::OFS_CTRL2, 32'h0000_0100, q);
		resetn <= 1'b0;
		repeat (16) @(posedge ref_clk);
		`CHK("irq_rst", 1'b0, core_irq)
		`CHK("addr_rst", 24'h00_0000, handler_addr)
		resetn <= 1'b1;
		foreach (rows[k])
		begin
			wb(1'b0, 12'(4 * (k % 4)), 32'h0000_0000, q);
			`CHK("reg_rst", 32'h0000_0000, q & ((k % 4 == 1) ? 32'h0000_FF00 : 32'hFFFF_FFFF))
		end
		print_verdict();
	end
endmodule // tb_top
